// file: spd_cfg.svh
// Constants for the pin-controlled sleep block
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define SPD_CLK_MHZ 25
`define SPD_WAKE_US 1
// Longest wake time rounds down: 1 us at 25 MHz is 25 cycles
`define SPD_WAKE_CYC ((`SPD_WAKE_US * `SPD_CLK_MHZ) > 0 ? \
    (`SPD_WAKE_US * `SPD_CLK_MHZ) : 1)
`define SPD_DATA_W 8
`define SPD_ENA_RST 1'h0
`define SPD_SYNC_STAGES 3
// Edges from a request pin change to the state register: three
// synchroniser stages, the filter register, then the state itself
`define SPD_REQ_LAT 5
`endif

// file: spd_pkg.sv
// Types for the pin-controlled sleep block
package spd_pkg;
    typedef enum logic [1:0] {SPD_RUN, SPD_SLEEP, SPD_WAKE} spd_state_e;
    // One group of user logic pins: data and output enable
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } spd_pins_s;
endpackage

// file: spd_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module spd_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin in, filtered level out
    input wire logic pin_in,
    output logic level_out
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic lvl_d;

    // A change counts once stages two and three agree
    always_comb
    begin
        lvl_d = lvl_q;
        if (s2_q == s3_q)
        begin
            lvl_d = s2_q;
        end
    end

    // Stage one is read by stage two only
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            lvl_q <= 1'h0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule // spd_sync
`default_nettype wire

// file: spd_sleep.sv
// Pin-controlled sleep: freezes user logic and pins while requested
//
// Functional notes
// - Sleep works only when the option strap is enabled; pin then is request
// - Request high with option on keeps sleep; request low leaves it
// - Entering sleep holds all outputs and registers; outputs stay driven
// - Outputs tri-stated at sleep onset stay tri-stated until wake
// - In sleep all inputs, enables and clock enables are ignored
// - Input hold latches stay active so pins keep a defined level
// - After request falls, inputs and outputs valid again within 1 us
`timescale 1ns/1ns
`default_nettype none
`include "spd_cfg.svh"
module spd_sleep #(
    parameter int unsigned WAKE_CYC = `SPD_WAKE_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration strap, caught after reset release
    input wire logic sleep_option_en,
    // Sleep request pin
    input wire logic sleep_request_pin,
    // User logic side: what the array wants on the pins
    input wire spd_pkg::spd_pins_s core_out,
    input wire logic core_clk_en,
    // User logic side: pin levels and clock enable as seen by the array
    output spd_pkg::spd_pins_s pin_out,
    output logic [`SPD_DATA_W-1:0] pin_in_held,
    output logic core_clk_en_gated,
    // Raw pad inputs
    input wire logic [`SPD_DATA_W-1:0] pad_in,
    // Status
    output logic sleep_active,
    output logic wake_busy
);
    import spd_pkg::*;

    // The wake budget runs from the pin edge, so the request path's own
    // latency is taken out of the counted wait. Without this the default
    // would overrun the budget by the synchroniser delay.
    localparam int unsigned REQ_LAT = `SPD_REQ_LAT;
    localparam int unsigned WAKE_SPAN = (WAKE_CYC > REQ_LAT) ?
        (WAKE_CYC - REQ_LAT) : 1;
    // Counter is 8 bits wide; longer budgets would need a wider counter
    localparam logic [7:0] WAKE_CNT = WAKE_SPAN[7:0];

    // Wake counter step, shared by the exit test and the increment
    function automatic logic [7:0] cnt_step(input logic [7:0] c);
        return c + 8'h01;
    endfunction

    logic req_lvl;
    logic opt_q, opt_d, opt_caught_q, opt_caught_d;
    spd_state_e st_q, st_d;
    logic [7:0] cnt_q, cnt_d;
    spd_pins_s pins_q, pins_d;
    logic [`SPD_DATA_W-1:0] hold_q, hold_d;
    logic [`SPD_DATA_W-1:0] pad_sync;
    logic ce_q, ce_d, act_q, act_d, busy_q, busy_d;

    // Request path latency, counted in rising edges after the pin moves:
    //   edges 1 to 3 fill the synchroniser, edge 4 updates the filtered
    //   level, edge 5 moves the state and the frozen outputs together.
    // A request shorter than two samples never reaches the state machine,
    // which is the price paid for ignoring single-cycle glitches.
    // Request pin comes from outside, so it is synchronised
    spd_sync u_req_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(sleep_request_pin),
        .level_out(req_lvl)
    );

    // Pads are synchronised per bit before the hold latch
    // Bits are independent levels, so no word coherence is needed here
    for (genvar i = 0; i < `SPD_DATA_W; i++)
    begin : g_pad
        spd_sync u_pad_sync (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .pin_in(pad_in[i]),
            .level_out(pad_sync[i])
        );
    end

    // Strap caught once on the first clock after reset release
    // A strap that moves later is ignored until the next reset: it is a
    // build-time choice, not a run-time control
    always_comb
    begin
        opt_d = opt_q;
        opt_caught_d = 1'h1;
        if (!opt_caught_q)
        begin
            opt_d = sleep_option_en;
        end
    end

    // Sleep sequencing; wake counter gives the pins time to settle
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            SPD_RUN:
            begin
                // Request only acts as sleep when the option is on
                if (opt_q && req_lvl)
                begin
                    st_d = SPD_SLEEP;
                end
            end
            SPD_SLEEP:
            begin
                if (!req_lvl)
                begin
                    st_d = SPD_WAKE;
                    cnt_d = 8'h00;
                end
            end
            SPD_WAKE:
            begin
                // Re-entry is allowed at once; state is still held
                // and the count starts over on the next wake
                if (req_lvl)
                begin
                    st_d = SPD_SLEEP;
                end
                else if (cnt_step(cnt_q) >= WAKE_CNT)
                begin
                    st_d = SPD_RUN;
                end
                else
                begin
                    cnt_d = cnt_step(cnt_q);
                end
            end
            // Two state bits hold one unused code; a stray upset lands
            // back in run rather than locking the pins frozen forever
            default:
            begin
                st_d = SPD_RUN;
                cnt_d = 8'h00;
            end
        endcase
    end

    // Freeze: pins and enables only follow the array while running
    // Outside logic may keep sampling the pins during sleep and still
    // see the values from the cycle before the state moved to sleep
    always_comb
    begin
        pins_d = pins_q;
        hold_d = hold_q;
        ce_d = 1'h0;
        if (st_d == SPD_RUN)
        begin
            pins_d = core_out;
            hold_d = pad_sync;
            ce_d = core_clk_en;
        end
        // Otherwise held data, held enables and a stopped clock:
        // tri-stated pins keep oe low, driven pins keep their value
        act_d = (st_d == SPD_SLEEP);
        busy_d = (st_d == SPD_WAKE);
    end

    // Strap capture registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opt_q <= `SPD_ENA_RST;
            opt_caught_q <= 1'h0;
        end
        else
        begin
            opt_q <= opt_d;
            opt_caught_q <= opt_caught_d;
        end
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= SPD_RUN;
            cnt_q <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Reset only by rst_n; wake never clears user state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_q <= '0;
            hold_q <= '0;
            ce_q <= 1'h0;
            act_q <= 1'h0;
            busy_q <= 1'h0;
        end
        else
        begin
            pins_q <= pins_d;
            hold_q <= hold_d;
            ce_q <= ce_d;
            act_q <= act_d;
            busy_q <= busy_d;
        end
    end

    // Outputs come straight from registers, so nothing the array does
    // within a cycle can glitch the pins
    assign pin_out = pins_q;
    assign pin_in_held = hold_q;
    assign core_clk_en_gated = ce_q;
    assign sleep_active = act_q;
    assign wake_busy = busy_q;
endmodule // spd_sleep
`default_nettype wire

// file: spd_monitor.sv
// Port checker for the sleep block
`timescale 1ns/1ns
`include "spd_cfg.svh"
`default_nettype none
module spd_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Strap, request, user side
    input wire logic sleep_option_en,
    input wire logic sleep_request_pin,
    input wire spd_pkg::spd_pins_s core_out,
    input wire spd_pkg::spd_pins_s pin_out,
    input wire logic [`SPD_DATA_W-1:0] pin_in_held,
    // Status
    input wire logic core_clk_en_gated,
    input wire logic sleep_active,
    input wire logic wake_busy
);
    import spd_pkg::*;
    logic run;
    // Running: neither asleep nor waiting out the wake time
    assign run = !sleep_active && !wake_busy;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_strap_only: assert property (sleep_active |-> sleep_option_en)
        else $error("sleep without strap");
    a_sleep_cause: assert property ($rose(sleep_active)
        |-> $past(sleep_request_pin, 4) && $past(sleep_request_pin, 5))
        else $error("sleep uncaused");
    a_sleep_leave: assert property (!sleep_request_pin [*8]
        |-> !sleep_active) else $error("sleep kept");
    a_hold_out: assert property (sleep_active ##1 sleep_active
        |-> $stable(pin_out)) else $error("pins moved");
    a_hold_in: assert property (sleep_active ##1 sleep_active
        |-> $stable(pin_in_held)) else $error("inputs moved");
    a_clk_gate: assert property (!run |-> !core_clk_en_gated)
        else $error("clock enabled");
    a_wake_time: assert property ($fell(sleep_active)
        |-> ##[0:25] !wake_busy) else $error("wake late");
    a_run_follow: assert property (run && $past(run) && $past(rst_n, 3)
        |-> pin_out == $past(core_out)) else $error("pins stale");
endmodule // spd_monitor
// Watch every instance of the block
bind spd_sleep spd_monitor mon_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sleep_option_en(sleep_option_en),
    .sleep_request_pin(sleep_request_pin),
    .core_out(core_out),
    .pin_out(pin_out),
    .pin_in_held(pin_in_held),
    .core_clk_en_gated(core_clk_en_gated),
    .sleep_active(sleep_active),
    .wake_busy(wake_busy)
);
`default_nettype wire

// file: spd_req_host.sv
// Outside logic that drives the sleep request pin
`timescale 1ns/1ns
`default_nettype none
module spd_req_host (
    // Clock
    input wire logic core_clk,
    // Wanted level in, pin out
    input wire logic want_sleep,
    output logic sleep_request_pin = 1'h0
);
    logic want_q = 1'h0;
    // Wanted level caught on the rising edge, so falling-edge bench
    // writes never race the pin update
    always @(posedge core_clk) want_q <= want_sleep;
    // Moves away from the sampling edge; never reads the pin back
    always @(negedge core_clk) sleep_request_pin <= want_q;
endmodule // spd_req_host
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the sleep block
`timescale 1ns/1ns
`default_nettype none
`include "spd_cfg.svh"
module testbench;
    import spd_pkg::*;
    logic core_clk = 1'h0, rst_n = 1'h0, opt = 1'h1, want = 1'h0;
    logic cen = 1'h1, req, sa, wb, gen;
    spd_pins_s co = 16'h0000, po;
    logic [7:0] pad = 8'h00, pih;
    int num_errors = 0, total_checks = 0, cyc = 0, n;
    always #20 core_clk = ~core_clk;
    spd_req_host host_u (.core_clk(core_clk), .want_sleep(want),
        .sleep_request_pin(req));
    // Default wake count, so the 1 us budget is tested as built
    spd_sleep dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .sleep_option_en(opt), .sleep_request_pin(req), .core_out(co),
        .core_clk_en(cen), .pin_out(po), .pin_in_held(pih),
        .core_clk_en_gated(gen), .pad_in(pad), .sleep_active(sa),
        .wake_busy(wb));
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    // Waits on the falling edge until the flag reaches v, n counts cycles
    // wake selects wake_busy, otherwise sleep_active is watched
    task automatic wait_lvl(input logic wake, input logic v);
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while ((wake ? wb : sa) !== v && n < 40);
    endtask
    // Strap changes only under reset since it is caught once
    task automatic do_reset(logic s);
        rst_n = 1'h0;
        opt = s;
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic t_sleep();
        co = 16'hA50F;
        pad = 8'h3C;
        repeat (6) @(negedge core_clk);
        chk("clk_en", gen, 1'h1);
        want = 1'h1;
        wait_lvl(1'h0, 1'h1);
        chk("sleep", sa, 1'h1);
        co = 16'h5AF0;
        pad = 8'hC3;
        repeat (6) @(negedge core_clk);
        chk("held_out", po, 16'hA50F);
        chk("held_in", pih, 16'h003C);
        chk("clk_gate", gen, 1'h0);
        want = 1'h0;
        // Budget runs from the pin edge, so count from there
        @(negedge req);
        wait_lvl(1'h1, 1'h1);
        chk("wake_held", po, 16'hA50F);
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (po !== 16'h5AF0 && n < 40);
        chk("wake_time", n <= `SPD_WAKE_CYC, 1'h1);
        chk("wake_done", {sa, wb}, 2'h0);
        repeat (6) @(negedge core_clk);
        chk("resume_out", po, 16'h5AF0);
        chk("resume_in", pih, 16'h00C3);
        $display("sleep test done");
    endtask
    task automatic t_no_strap();
        do_reset(1'h0);
        want = 1'h1;
        co = 16'h1234;
        repeat (12) @(negedge core_clk);
        chk("no_sleep", sa, 1'h0);
        chk("live_out", po, 16'h1234);
        want = 1'h0;
        $display("strap test done");
    endtask
    initial
    begin
        do_reset(1'h1);
        t_sleep();
        t_no_strap();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
